// file: adc_port_pkg.sv
package adc_port_pkg;

  // ****************************************
  // Word and field sizes
  // ****************************************
  localparam int RESULT_W = 12;
  localparam int SHIFT_W  = 16;
  localparam int CMD_W    = 8;
  localparam int BITS_W   = 5;
  localparam int CONV_W   = 6;

  // ****************************************
  // Transfer length codes and values
  // ****************************************
  localparam logic [1:0] LEN_CODE_8  = 2'h0;
  localparam logic [1:0] LEN_CODE_12 = 2'h1;
  localparam logic [1:0] LEN_CODE_16 = 2'h2;
  localparam logic [BITS_W-1:0] LEN_8  = 5'h08;
  localparam logic [BITS_W-1:0] LEN_12 = 5'h0C;
  localparam logic [BITS_W-1:0] LEN_16 = 5'h10;

  // ****************************************
  // Timing counts
  // ****************************************
  localparam logic [BITS_W-1:0] SAMPLE_START_BIT = 5'h04;
  localparam logic [CONV_W-1:0] CONV_CYCLES      = 6'h34;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [RESULT_W-1:0] RESULT_RST = 12'h000;
  localparam logic [CMD_W-1:0]    CMD_RST    = 8'h00;

endpackage

// file: pin_sync.sv
`timescale 1ns/10ps

// ****************************************
// Three-stage pin synchroniser
// ****************************************
module pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      level_o
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic level_next;

  // New level only once stages two and three agree
  always_comb
  begin
    level_next = level_reg;
    if (s2_reg == s3_reg)
    begin
      level_next = s3_reg;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s1_reg    <= RST_VAL;
      s2_reg    <= RST_VAL;
      s3_reg    <= RST_VAL;
      level_reg <= RST_VAL;
    end
    else
    begin
      s1_reg    <= pin_i;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;

endmodule // pin_sync

// file: adc_serial_sample_port.sv
// Contract
// - Shared lines are fine; each device answers only while selected.
// - Sampling of the positive input starts at the fourth shift clock.
// - Sampling lasts to the last falling edge: 8th, 12th or 16th clock.
// - At the end of sampling the input is held and conversion starts; the code ignores start_conv while an earlier conversion is still in CONV_RUN.
// - The sample window grows with clock period and word length.
// - While select is high all shift-clock activity is ignored.
// - Data change on the falling edge and are taken on the rising edge.
// - Each conversion takes fifty-two conversion-clock cycles.
`timescale 1ns/10ps

module adc_serial_sample_port (
  input  wire logic                           ref_clk_i,
  input  wire logic                           rst_n_i,
  input  wire logic                           cs_n_i,
  input  wire logic                           sclk_i,
  input  wire logic                           din_i,
  input  wire logic                           aclk_i,
  input  wire logic [1:0]                     word_len_i,
  input  wire logic                           msb_first_i,
  input  wire logic [adc_port_pkg::RESULT_W-1:0] conv_data_i,
  output logic                                dout_o,
  output logic                                dout_oe_o,
  output logic                                sample_o,
  output logic                                hold_o,
  output logic [adc_port_pkg::CMD_W-1:0]      cmd_o,
  output logic [adc_port_pkg::RESULT_W-1:0]   result_o,
  output logic                                result_valid_o
);

  typedef enum logic [1:0] {XFER_IDLE, XFER_SHIFT, XFER_DONE} xfer_t;
  typedef enum logic {CONV_IDLE, CONV_RUN} conv_t;

  // ****************************************
  // Pin sampling
  // ****************************************
  logic cs_n_lvl;
  logic sclk_lvl;
  logic din_lvl;
  logic aclk_lvl;
  logic sclk_prev_reg;
  logic aclk_prev_reg;

  pin_sync #(.RST_VAL(1'b1)) u_cs (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .pin_i(cs_n_i), .level_o(cs_n_lvl));
  pin_sync #(.RST_VAL(1'b0)) u_sclk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .pin_i(sclk_i), .level_o(sclk_lvl));
  pin_sync #(.RST_VAL(1'b0)) u_din (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .pin_i(din_i), .level_o(din_lvl));
  pin_sync #(.RST_VAL(1'b0)) u_aclk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .pin_i(aclk_i), .level_o(aclk_lvl));

  logic sclk_rise;
  logic sclk_fall;
  logic aclk_rise;
  assign sclk_rise = sclk_lvl & ~sclk_prev_reg;
  assign sclk_fall = ~sclk_lvl & sclk_prev_reg;
  assign aclk_rise = aclk_lvl & ~aclk_prev_reg;

  // ****************************************
  // Serial transfer
  // ****************************************
  xfer_t                              xfer_reg;
  xfer_t                              xfer_next;
  logic [adc_port_pkg::BITS_W-1:0]    bit_cnt_reg;
  logic [adc_port_pkg::BITS_W-1:0]    bit_cnt_next;
  logic [adc_port_pkg::BITS_W-1:0]    len_reg;
  logic [adc_port_pkg::BITS_W-1:0]    len_next;
  logic                               msb_reg;
  logic                               msb_next;
  logic [adc_port_pkg::SHIFT_W-1:0]   sh_reg;
  logic [adc_port_pkg::SHIFT_W-1:0]   sh_next;
  logic [adc_port_pkg::CMD_W-1:0]     cmd_reg;
  logic [adc_port_pkg::CMD_W-1:0]     cmd_next;
  logic                               dout_reg;
  logic                               dout_next;
  logic                               oe_reg;
  logic                               oe_next;
  logic                               sample_reg;
  logic                               sample_next;
  logic                               start_conv;
  logic [adc_port_pkg::SHIFT_W-1:0]   sh_load;
  logic [adc_port_pkg::RESULT_W-1:0]  result_reg;

  function automatic logic [adc_port_pkg::BITS_W-1:0] len_of(
    input logic [1:0] code);
    unique case (code)
      adc_port_pkg::LEN_CODE_8:  len_of = adc_port_pkg::LEN_8;
      adc_port_pkg::LEN_CODE_12: len_of = adc_port_pkg::LEN_12;
      default:                   len_of = adc_port_pkg::LEN_16;
    endcase
  endfunction

  always_comb
  begin
    xfer_next    = xfer_reg;
    bit_cnt_next = bit_cnt_reg;
    len_next     = len_reg;
    msb_next     = msb_reg;
    sh_next      = sh_reg;
    cmd_next     = cmd_reg;
    dout_next    = dout_reg;
    oe_next      = oe_reg;
    sample_next  = sample_reg;
    start_conv   = 1'b0;
    // Unused tail of a 16-bit word shifts out as zeros
    sh_load = msb_first_i ? {result_reg, 4'h0} : {4'h0, result_reg};
    // select high
    // Aborted transfers start no conversion
    if (cs_n_lvl)
    begin
      xfer_next    = XFER_IDLE;
      bit_cnt_next = '0;
      oe_next      = 1'b0;
      sample_next  = 1'b0;
    end
    else
    begin
      unique case (xfer_reg)
        XFER_IDLE:
        begin
          xfer_next    = XFER_SHIFT;
          oe_next      = 1'b1;
          len_next     = len_of(word_len_i);
          msb_next     = msb_first_i;
          sh_next      = sh_load;
          dout_next    = msb_first_i ? sh_load[adc_port_pkg::SHIFT_W-1]
                                     : sh_load[0];
          bit_cnt_next = '0;
        end
        XFER_SHIFT:
        begin
          if (sclk_rise)
          begin
            cmd_next     = {cmd_reg[adc_port_pkg::CMD_W-2:0], din_lvl};
            bit_cnt_next = bit_cnt_reg + 5'h01;
            if (bit_cnt_next == adc_port_pkg::SAMPLE_START_BIT)
            begin
              sample_next = 1'b1;
            end
          end
          else if (sclk_fall)
          begin
            if (bit_cnt_reg == len_reg)
            begin
              sample_next = 1'b0;
              start_conv  = 1'b1;
              xfer_next   = XFER_DONE;
            end
            else
            begin
              sh_next   = msb_reg ? (sh_reg << 1) : (sh_reg >> 1);
              dout_next = msb_reg ? sh_next[adc_port_pkg::SHIFT_W-1]
                                  : sh_next[0];
            end
          end
        end
        XFER_DONE:
        begin
          // Extra clocks past the word are ignored
          xfer_next = XFER_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      xfer_reg      <= XFER_IDLE;
      bit_cnt_reg   <= '0;
      len_reg       <= adc_port_pkg::LEN_12;
      msb_reg       <= 1'b1;
      sh_reg        <= '0;
      cmd_reg       <= adc_port_pkg::CMD_RST;
      dout_reg      <= 1'b0;
      oe_reg        <= 1'b0;
      sample_reg    <= 1'b0;
      sclk_prev_reg <= 1'b0;
      aclk_prev_reg <= 1'b0;
    end
    else
    begin
      xfer_reg      <= xfer_next;
      bit_cnt_reg   <= bit_cnt_next;
      len_reg       <= len_next;
      msb_reg       <= msb_next;
      sh_reg        <= sh_next;
      cmd_reg       <= cmd_next;
      dout_reg      <= dout_next;
      oe_reg        <= oe_next;
      sample_reg    <= sample_next;
      sclk_prev_reg <= sclk_lvl;
      aclk_prev_reg <= aclk_lvl;
    end
  end

  // ****************************************
  // Conversion timing
  // ****************************************
  conv_t                           conv_reg;
  conv_t                           conv_next;
  logic [adc_port_pkg::CONV_W-1:0] conv_cnt_reg;
  logic [adc_port_pkg::CONV_W-1:0] conv_cnt_next;
  logic [adc_port_pkg::RESULT_W-1:0] result_next;
  logic                            valid_reg;
  logic                            valid_next;

  always_comb
  begin
    conv_next     = conv_reg;
    conv_cnt_next = conv_cnt_reg;
    result_next   = result_reg;
    valid_next    = 1'b0;
    unique case (conv_reg)
      CONV_IDLE:
      begin
        if (start_conv)
        begin
          conv_next     = CONV_RUN;
          conv_cnt_next = '0;
        end
      end
      CONV_RUN:
      begin
        if (aclk_rise)
        begin
          conv_cnt_next = conv_cnt_reg + 6'h01;
          if (conv_cnt_next == adc_port_pkg::CONV_CYCLES)
          begin
            conv_next   = CONV_IDLE;
            result_next = conv_data_i;
            valid_next  = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      conv_reg     <= CONV_IDLE;
      conv_cnt_reg <= '0;
      result_reg   <= adc_port_pkg::RESULT_RST;
      valid_reg    <= 1'b0;
    end
    else
    begin
      conv_reg     <= conv_next;
      conv_cnt_reg <= conv_cnt_next;
      result_reg   <= result_next;
      valid_reg    <= valid_next;
    end
  end

  assign dout_o         = dout_reg;
  assign dout_oe_o      = oe_reg;
  assign sample_o       = sample_reg;
  assign hold_o         = (conv_reg == CONV_RUN);
  assign cmd_o          = cmd_reg;
  assign result_o       = result_reg;
  assign result_valid_o = valid_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence last_fall_s;
    (xfer_reg == XFER_SHIFT) && !cs_n_lvl && sclk_fall
      && (bit_cnt_reg == len_reg);
  endsequence

  sequence conv_begin_s;
    !sample_reg && (conv_reg == CONV_RUN) && (conv_cnt_reg == 6'h00);
  endsequence

  cs_ignore_a: assert property (
    cs_n_lvl |=> (bit_cnt_reg == 5'h00) && !sample_reg && !oe_reg)
    else $error("port active while select high");

  sample_start_a: assert property (
    (xfer_reg == XFER_SHIFT) && !cs_n_lvl && sclk_rise
      && (bit_cnt_reg == 5'h03) |=> sample_reg)
    else $error("sampling did not begin at fourth clock");

  sample_end_a: assert property (
    last_fall_s |=> conv_begin_s)
    else $error("sample phase did not end at last fall");

  sample_span_a: assert property (
    sample_reg |-> (bit_cnt_reg >= 5'h04) && (bit_cnt_reg <= len_reg))
    else $error("sample window outside word");

  hold_cause_a: assert property (
    $rose(conv_reg == CONV_RUN) |-> $past(sample_reg) && !sample_reg)
    else $error("conversion started without sample phase");

  conv_len_a: assert property (
    $fell(conv_reg == CONV_RUN) |-> $past(conv_cnt_reg) == 6'h33
      && valid_reg)
    else $error("conversion length not fifty-two");

  dout_edge_a: assert property (
    !cs_n_lvl && $past(!cs_n_lvl) && (xfer_reg != XFER_IDLE)
      && $past(xfer_reg != XFER_IDLE) && $changed(dout_reg)
      |-> $past(sclk_fall))
    else $error("output bit changed off falling edge");

  cmd_edge_a: assert property (
    $changed(cmd_reg) |-> $past(sclk_rise) && $past(!cs_n_lvl))
    else $error("command bit taken off rising edge");

  bit_count_a: assert property (
    (xfer_reg == XFER_DONE) |-> bit_cnt_reg == len_reg)
    else $error("word ended at wrong pulse count");

endmodule // adc_serial_sample_port

// file: host_port_model.sv
`timescale 1ns/10ps

// ****************************************
// Port-pin host driving the serial link
// ****************************************
module host_port_model (
  input  wire logic        ref_clk_i,
  input  wire logic        go_i,
  input  wire logic        sel_i,
  input  wire logic [4:0]  pulses_i,
  input  wire logic [15:0] cmd_i,
  input  wire logic        dout_i,
  output logic             cs_n_o,
  output logic             sclk_o,
  output logic             din_o,
  output logic             done_o,
  output logic [15:0]      rx_o
);
  int i;

  initial
  begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o  = 1'b0;
    done_o = 1'b0;
    rx_o   = 16'h0000;
  end

  always
  begin
    @(posedge ref_clk_i iff go_i);
    #1;
    rx_o = 16'h0000;
    cs_n_o = ~sel_i;
    repeat (8) @(posedge ref_clk_i);
    #1;
    // bit set on fall, one pulse per bit
    for (i = 0; i < int'(pulses_i); i++)
    begin
      din_o = cmd_i[15-i];
      repeat (4) @(posedge ref_clk_i);
      #1;
      sclk_o = 1'b1;
      repeat (4) @(posedge ref_clk_i);
      #1;
      // Read late in the high phase: port lag exceeds half a period
      rx_o   = {rx_o[14:0], dout_i};
      sclk_o = 1'b0;
    end
    repeat (8) @(posedge ref_clk_i);
    #1;
    // release select after the last clock
    cs_n_o = 1'b1;
    din_o  = ~din_o;
    repeat (4) @(posedge ref_clk_i);
    #1;
    done_o = 1'b1;
    @(posedge ref_clk_i iff !go_i);
    #1;
    done_o = 1'b0;
  end
endmodule // host_port_model

// file: tb_top.sv
`timescale 1ns/10ps

module tb_top;
  logic        ref_clk, rst_n, aclk, go, sel, msb_first, oe_seen;
  logic        dout, dout_oe, sample, hold, result_valid, cs_n, sclk;
  logic        din, done;
  logic [1:0]  word_len;
  logic [4:0]  pulses;
  logic [15:0] cmd, rx;
  logic [11:0] conv_data, result, last_res;
  logic [7:0]  cmd_out;
  int          err_count, n_tests, smp_cnt, acnt;

  // ****************************************
  // Clocks, monitors, instances
  // ****************************************
  always #20 ref_clk = ~ref_clk;
  always #200 aclk = ~aclk;
  always @(posedge ref_clk) if (sample === 1'b1) smp_cnt++;
  always @(posedge ref_clk) if (dout_oe === 1'b1) oe_seen = 1'b1;
  always @(posedge aclk) if (hold === 1'b1) acnt++;

  adc_serial_sample_port adc_serial_sample_port_i (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .cs_n_i(cs_n), .sclk_i(sclk),
    .din_i(din), .aclk_i(aclk), .word_len_i(word_len),
    .msb_first_i(msb_first), .conv_data_i(conv_data), .dout_o(dout),
    .dout_oe_o(dout_oe), .sample_o(sample), .hold_o(hold),
    .cmd_o(cmd_out), .result_o(result), .result_valid_o(result_valid));

  host_port_model host_port_model_i (
    .ref_clk_i(ref_clk), .go_i(go), .sel_i(sel), .pulses_i(pulses),
    .cmd_i(cmd), .dout_i(dout_oe ? dout : ~dout), .cs_n_o(cs_n),
    .sclk_o(sclk),
    .din_o(din), .done_o(done), .rx_o(rx));

  // ****************************************
  // Shared tasks
  // ****************************************
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task chk_near(input string nm, input int e, input int g);
    n_tests++;
    if (g < e - 1 || g > e + 1)
    begin
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
      err_count++;
    end
  endtask

  function logic [15:0] exp_word(input logic [11:0] r, input int n,
                                 input logic m);
    logic [15:0] w;
    w = 16'h0000;
    for (int k = 0; k < n; k++)
      w[n-1-k] = (k < 12) ? (m ? r[11-k] : r[k]) : 1'b0;
    return w;
  endfunction

  task xfer(input logic s, input int n, input logic [1:0] code,
            input logic m, input logic [15:0] c);
    int t;
    // Previous handshake must be fully closed first
    @(posedge ref_clk iff done === 1'b0);
    #1;
    sel = s;
    pulses = n[4:0];
    word_len = code;
    msb_first = m;
    cmd = c;
    smp_cnt = 0;
    acnt = 0;
    oe_seen = 1'b0;
    go = 1'b1;
    t = 0;
    while (done !== 1'b1 && t < 2000)
    begin
      @(posedge ref_clk);
      t++;
    end
    #1;
    go = 1'b0;
    if (t >= 2000) chk("transfer done", 16'h0001, 16'h0000);
  endtask

  // Waits out the conversion before any further select fall
  task wait_conv(input logic [11:0] v);
    int t;
    t = 0;
    while (result_valid !== 1'b1 && t < 1500)
    begin
      @(negedge ref_clk);
      t++;
    end
    chk("result valid", 16'h0001, {15'h0000, result_valid});
    chk("result", {4'h0, v}, {4'h0, result});
    chk("hold end", 16'h0000, {15'h0000, hold});
    chk_near("aclk count", 52, acnt);
    last_res = v;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task sc_msb12;
    conv_data = 12'hA5C;
    xfer(1'b1, 12, adc_port_pkg::LEN_CODE_12, 1'b1, 16'hE3A5);
    chk("rx word", exp_word(last_res, 12, 1'b1), rx);
    chk("command", 16'h003A, {8'h00, cmd_out});
    chk_near("sample window", 68, smp_cnt);
    chk("hold", 16'h0001, {15'h0000, hold});
    chk("oe seen", 16'h0001, {15'h0000, oe_seen});
    wait_conv(12'hA5C);
  endtask

  task sc_lsb16;
    conv_data = 12'h3C7;
    xfer(1'b1, 16, 2'h3, 1'b0, 16'h5AF0);
    chk("rx word", exp_word(last_res, 16, 1'b0), rx);
    chk("command", 16'h00F0, {8'h00, cmd_out});
    chk_near("sample window", 100, smp_cnt);
    wait_conv(12'h3C7);
  endtask

  task sc_len8;
    conv_data = 12'h81E;
    xfer(1'b1, 8, adc_port_pkg::LEN_CODE_8, 1'b1, 16'hC300);
    chk("rx word", exp_word(last_res, 8, 1'b1), rx);
    chk("command", 16'h00C3, {8'h00, cmd_out});
    chk_near("sample window", 36, smp_cnt);
    wait_conv(12'h81E);
  endtask

  task sc_ignore;
    xfer(1'b0, 8, adc_port_pkg::LEN_CODE_12, 1'b1, 16'hFFFF);
    chk("oe seen", 16'h0000, {15'h0000, oe_seen});
    chk_near("sample window", 0, smp_cnt);
    chk("command", 16'h00C3, {8'h00, cmd_out});
  endtask

  task sc_abort;
    xfer(1'b1, 6, adc_port_pkg::LEN_CODE_16, 1'b1, 16'hFFFF);
    chk("rx word", exp_word(last_res, 6, 1'b1), rx);
    repeat (600) @(posedge ref_clk);
    chk("hold", 16'h0000, {15'h0000, hold});
    chk("result", {4'h0, last_res}, {4'h0, result});
  endtask

  task test_done;
    if (err_count == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    ref_clk = 1'b0;
    aclk = 1'b0;
    rst_n = 1'b0;
    go = 1'b0;
    sel = 1'b0;
    pulses = 5'h00;
    cmd = 16'h0000;
    word_len = adc_port_pkg::LEN_CODE_12;
    msb_first = 1'b1;
    conv_data = 12'h000;
    last_res = adc_port_pkg::RESULT_RST;
    err_count = 0;
    n_tests = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    sc_msb12();
    sc_lsb16();
    sc_len8();
    sc_ignore();
    sc_abort();
    test_done();
  end

  // Whole run needs about 2700 cycles
  initial
  begin
    #800000;
    err_count++;
    test_done();
  end
endmodule // tb_top
